// [shared/pss_pkg.sv]
// package for the parameter set switch: register map, layouts, resets
// assumes a 50 MHz clock and a 32-bit avalon-mm register bus
package pss_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_SETS   = 4;
  localparam int NUM_PARAMS = 32;
  localparam int PARAM_W    = 16;
  localparam int ADDR_W     = 12;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS    = 12'h000;
  localparam logic [11:0] STATUS_OFS  = 12'h004;
  localparam logic [2:0]  PARAM_PAGE  = 3'h1;   // 0x200..0x3fc

  // ctrl field positions
  localparam int CTRL_METHOD_LSB = 0;
  localparam int CTRL_SRC_LSB    = 2;

  // status field positions
  localparam int STAT_APPLIED_LSB = 0;
  localparam int STAT_DRV_EN_BIT  = 2;
  localparam int STAT_SEL_LSB     = 3;
  localparam int STAT_REJ_BIT     = 5;

  // reset values
  localparam logic [1:0] METHOD_RST  = 2'h1;
  localparam logic [1:0] SRC_RST     = 2'h0;   // no source connected
  localparam logic [1:0] APPLIED_RST = 2'h0;

  // load trigger source codes; 0 means not connected
  localparam logic [1:0] SRC_NONE = 2'h0;

  typedef enum logic [1:0] {
    PSS_ACT_SEL_NOW,
    PSS_ACT_LOAD_NOW,
    PSS_ACT_SEL_INHIB,
    PSS_ACT_LOAD_INHIB
  } pss_method_t;

endpackage

// [logic/pss_parameter_set_switch.sv]
// parameter set switch: four stored value sets, one applied at a time
// assumes pin inputs are asynchronous and the bus master is avalon-mm
`timescale 1ns/1ps

module pss_parameter_set_switch
  import pss_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // trigger pins
  input  wire logic              set_select_low_bit,
  input  wire logic              set_select_high_bit,
  input  wire logic [2:0]        load_src_pins,
  input  wire logic              drive_enabled,
  // applied parameter read port (same clock)
  input  wire logic [4:0]        param_sel,
  output logic      [PARAM_W-1:0] param_value,
  output logic      [1:0]        applied_set
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] pin_raw;
  wire  [NSYNC-1:0] sync2_q;

  assign pin_raw = {drive_enabled, load_src_pins,
                    set_select_high_bit, set_select_low_bit};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      logic s1_reg;
      logic s2_reg;
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
        end else begin
          s1_reg <= pin_raw[gi];
          s2_reg <= s1_reg;
        end
      end
      // only the second stage leaves the loop, never the first
      assign sync2_q[gi] = s2_reg;
    end
  endgenerate

  wire       drv_en  = sync2_q[5];
  wire [2:0] src_lvl = sync2_q[4:2];
  // low-bit trigger gives bit 0, high-bit trigger gives bit 1
  wire [1:0] sel_idx = {sync2_q[1], sync2_q[0]};

  // ----------------------------------------------------------------
  // configuration and state
  // ----------------------------------------------------------------
  logic [1:0] method_reg;
  logic [1:0] src_reg;
  logic [1:0] applied_reg;
  logic [1:0] sel_prev_reg;
  logic       load_prev_reg;
  logic       rej_reg;
  logic       ack_reg;
  logic [PARAM_W-1:0] store [NUM_SETS*NUM_PARAMS];

  pss_method_t method;
  assign method = pss_method_t'(method_reg);

  // code 0 selects no source, so the trigger reads false
  wire load_lvl = (src_reg == SRC_NONE) ? 1'b0
                : src_lvl[src_reg - 2'h1];
  wire load_rise = load_lvl & ~load_prev_reg;
  wire sel_chg   = (sel_idx != sel_prev_reg);

  // inhibited-only methods act only while the drive output is off; events while driving are dropped
  wire inhib_ok  = ~drv_en;
  logic chg_evt;
  always_comb begin
    case (method)
      PSS_ACT_SEL_NOW:    chg_evt = sel_chg;
      PSS_ACT_LOAD_NOW:   chg_evt = load_rise;
      PSS_ACT_SEL_INHIB:  chg_evt = sel_chg & inhib_ok;
      PSS_ACT_LOAD_INHIB: chg_evt = load_rise & inhib_ok;
      default:            chg_evt = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire        req      = read | write;
  wire        wr_go    = write & ack_reg;
  wire        hit_ctrl = (address == CTRL_OFS);
  wire        hit_stat = (address == STATUS_OFS);
  wire        hit_par  = (address[11:9] == PARAM_PAGE);
  wire [1:0]  tgt_set  = address[8:7];
  wire [6:0]  par_idx  = address[8:2];
  // the live set must not be rewritten under a running drive
  wire        par_crit = (tgt_set == applied_reg) & drv_en;
  wire        store_we = wr_go & hit_par & ~par_crit;
  wire        store_rej = wr_go & hit_par & par_crit;

  assign waitrequest = req & ~ack_reg;

  wire [31:0] status_word = {26'h0, rej_reg, sel_idx, drv_en,
                             applied_reg};
  wire [31:0] rd_mux = hit_ctrl ? {28'h0, src_reg, method_reg}
                     : hit_stat ? status_word
                     : hit_par  ? {16'h0, store[par_idx]}
                     : 32'h0;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg  <= 1'b0;
      readdata <= 32'h0;
    end else begin
      ack_reg  <= req & ~ack_reg;
      readdata <= rd_mux;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      method_reg <= METHOD_RST;
      src_reg    <= SRC_RST;
    end else if (wr_go & hit_ctrl) begin
      method_reg <= writedata[CTRL_METHOD_LSB +: 2];
      src_reg    <= writedata[CTRL_SRC_LSB +: 2];
    end
  end

  // a rejection and its clear in one cycle: the rejection stays
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rej_reg <= 1'b0;
    end else if (store_rej) begin
      rej_reg <= 1'b1;
    end else if (wr_go & hit_stat & writedata[STAT_REJ_BIT]) begin
      rej_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (store_we) begin
      store[par_idx] <= writedata[PARAM_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      applied_reg   <= APPLIED_RST;
      sel_prev_reg  <= 2'h0;
      load_prev_reg <= 1'b0;
    end else begin
      sel_prev_reg  <= sel_idx;
      load_prev_reg <= load_lvl;
      if (chg_evt) begin
        applied_reg <= sel_idx;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      param_value <= '0;
    end else begin
      param_value <= store[{applied_reg, param_sel}];
    end
  end

  assign applied_set = applied_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_hold;
    (applied_reg != $past(applied_reg)) |-> $past(chg_evt);
  endproperty
  a_hold: assert property (p_hold)
    else $error("applied set changed without an event");

  property p_index;
    chg_evt |=> (applied_reg == $past(sel_idx));
  endproperty
  a_index: assert property (p_index)
    else $error("applied set differs from selected index");

  property p_sel_change;
    (method == PSS_ACT_SEL_NOW) && (sel_idx != sel_prev_reg)
      |=> applied_reg == $past(sel_idx);
  endproperty
  a_sel_change: assert property (p_sel_change)
    else $error("select change did not switch set");

  property p_load_edge;
    (method == PSS_ACT_LOAD_NOW) && load_lvl && !load_prev_reg
      |=> applied_reg == $past(sel_idx);
  endproperty
  a_load_edge: assert property (p_load_edge)
    else $error("load edge did not switch set");

  property p_no_load;
    (method == PSS_ACT_LOAD_NOW || method == PSS_ACT_LOAD_INHIB)
      && !load_lvl |-> !chg_evt;
  endproperty
  a_no_load: assert property (p_no_load)
    else $error("switch without load trigger");

  property p_no_src;
    (src_reg == SRC_NONE) && (method == PSS_ACT_LOAD_NOW ||
      method == PSS_ACT_LOAD_INHIB) |=> applied_reg == $past(applied_reg);
  endproperty
  a_no_src: assert property (p_no_src)
    else $error("unconnected load source reads true");

  property p_live;
    (method == PSS_ACT_SEL_NOW) && drv_en && sel_chg |-> chg_evt;
  endproperty
  a_live: assert property (p_live)
    else $error("immediate method held back while driving");

  property p_crit;
    wr_go && hit_par && (tgt_set == applied_reg) && drv_en
      |-> !store_we ##1 rej_reg;
  endproperty
  a_crit: assert property (p_crit)
    else $error("live set written while drive enabled");

  property p_bus;
    req |-> ##[0:1] !waitrequest;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus answer later than one wait cycle");

  // end effects: the applied set itself, not only the event wire
  property p_sel_inhib;
    (method == PSS_ACT_SEL_INHIB) && drv_en
      |=> applied_reg == $past(applied_reg);
  endproperty
  a_sel_inhib: assert property (p_sel_inhib)
    else $error("select change applied while driving");

  property p_load_inhib;
    (method == PSS_ACT_LOAD_INHIB) && drv_en
      |=> applied_reg == $past(applied_reg);
  endproperty
  a_load_inhib: assert property (p_load_inhib)
    else $error("load edge applied while driving");

  property p_load_inhib_ok;
    (method == PSS_ACT_LOAD_INHIB) && !drv_en && load_rise
      |=> applied_reg == $past(sel_idx);
  endproperty
  a_load_inhib_ok: assert property (p_load_inhib_ok)
    else $error("load edge ignored while drive off");

  property p_sel_ignored;
    (method == PSS_ACT_LOAD_NOW || method == PSS_ACT_LOAD_INHIB)
      && sel_chg && !load_rise |=> applied_reg == $past(applied_reg);
  endproperty
  a_sel_ignored: assert property (p_sel_ignored)
    else $error("select change switched under a load-edge method");

  // the rejection flag is sticky until software clears it
  property p_rej_sticky;
    rej_reg && !(wr_go && hit_stat && writedata[STAT_REJ_BIT])
      |=> rej_reg;
  endproperty
  a_rej_sticky: assert property (p_rej_sticky)
    else $error("rejection flag lost without a clear");

  property p_rej_clear;
    wr_go && hit_stat && writedata[STAT_REJ_BIT] && !store_rej
      |=> !rej_reg;
  endproperty
  a_rej_clear: assert property (p_rej_clear)
    else $error("rejection flag not cleared");

  property p_cfg_write;
    wr_go && hit_ctrl
      |=> (method_reg == $past(writedata[CTRL_METHOD_LSB +: 2]))
          && (src_reg == $past(writedata[CTRL_SRC_LSB +: 2]));
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("configuration write not taken");

endmodule

// [dv/pss_trig_src.sv]
// trigger source model: select, load and drive enable pins
// assumes bench commands change only just after a rising edge
`timescale 1ns/1ps

module pss_trig_src (
  input  wire logic       clk,
  input  wire logic [1:0] idx_cmd,
  input  wire logic [2:0] ld_cmd,
  input  wire logic       en_cmd,
  output logic            set_select_low_bit,
  output logic            set_select_high_bit,
  output logic      [2:0] load_src_pins,
  output logic            drive_enabled
);
  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // one edge of lag, like a controller output stage
  always_ff @(posedge clk) begin
    set_select_low_bit  <= idx_cmd[0];
    set_select_high_bit <= idx_cmd[1];
    load_src_pins       <= ld_cmd;
    drive_enabled       <= en_cmd;
  end
endmodule

// [dv/tb.sv]
// bench for the parameter set switch: load table, then edge cases
// assumes the trigger model drives every pin of the switch
`timescale 1ns/1ps

module tb;
  import pss_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic               clk, nrst, read, write, waitrequest, en_cmd;
  logic               set_select_low_bit, set_select_high_bit;
  logic               drive_enabled;
  logic [ADDR_W-1:0]  address;
  logic [31:0]        writedata, readdata, rd;
  logic [1:0]         idx_cmd, applied_set, prev;
  logic [2:0]         ld_cmd, load_src_pins;
  logic [4:0]         param_sel;
  logic [PARAM_W-1:0] param_value;
  int                 err_count, cmp_count;
  typedef struct {logic [1:0] src; logic [1:0] idx;} pss_row_t;
  pss_row_t rows [4] = '{'{2'h1, 2'h1}, '{2'h2, 2'h2},
                         '{2'h3, 2'h3}, '{2'h1, 2'h0}};

  pss_parameter_set_switch DUT (.clk, .nrst, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .set_select_low_bit,
    .set_select_high_bit, .load_src_pins, .drive_enabled, .param_sel,
    .param_value, .applied_set);
  pss_trig_src src_model (.clk, .idx_cmd, .ld_cmd, .en_cmd,
    .set_select_low_bit, .set_select_high_bit, .load_src_pins,
    .drive_enabled);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("errors=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic we, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    read <= !we;
    write <= we;
    address <= a;
    writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (i == 20) begin
      err_count++;
      summarize();
    end
  endtask
  // pins take a few edges through the synchronisers, so 6 is ample
  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    ld_cmd <= m;
    wt(6);
    ld_cmd <= 3'h0;
    wt(6);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    idx_cmd = 2'h0;
    ld_cmd = 3'h0;
    en_cmd = 1'b0;
    param_sel = 5'h1f;
    wt(16);
    nrst <= 1'b1;
    chk(applied_set, APPLIED_RST);
    bus(1'b0, CTRL_OFS, 32'h0);
    chk(rd[3:0], {SRC_RST, METHOD_RST});
    for (int s = 0; s < 4; s++)
      bus(1'b1, 12'(12'h200 + (s * 32 + 31) * 4), 32'(16'h5a00 + s));
    idx_cmd <= 2'h3;
    pulse(3'h7);
    chk(applied_set, 2'h0);
    prev = 2'h0;
    foreach (rows[r]) begin
      bus(1'b1, CTRL_OFS, {28'h0, rows[r].src, 2'h1});
      idx_cmd <= rows[r].idx;
      wt(6);
      chk(applied_set, prev);
      pulse(3'h1 << (rows[r].src - 2'h1));
      chk(applied_set, rows[r].idx);
      chk(param_value, 16'h5a00 + rows[r].idx);
      prev = rows[r].idx;
    end
    // select-change method while driving switches at once
    en_cmd <= 1'b1;
    bus(1'b1, CTRL_OFS, 32'h0);
    idx_cmd <= 2'h2;
    wt(6);
    chk(applied_set, 2'h2);
    bus(1'b1, 12'(12'h200 + (2 * 32 + 31) * 4), 32'h1234);
    bus(1'b0, 12'(12'h200 + (2 * 32 + 31) * 4), 32'h0);
    chk(rd, 32'h5a02);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk(rd, 32'h36);
    bus(1'b1, STATUS_OFS, 32'h20);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk(rd, 32'h16);
    // inhibited-only method drops events while driving, no queueing
    bus(1'b1, CTRL_OFS, 32'h2);
    idx_cmd <= 2'h3;
    wt(6);
    chk(applied_set, 2'h2);
    en_cmd <= 1'b0;
    wt(6);
    chk(applied_set, 2'h2);
    idx_cmd <= 2'h1;
    wt(6);
    chk(applied_set, 2'h1);
    // load-edge method held off while driving, honoured once off
    bus(1'b1, CTRL_OFS, 32'h7);
    en_cmd <= 1'b1;
    idx_cmd <= 2'h2;
    wt(6);
    pulse(3'h1);
    chk(applied_set, 2'h1);
    en_cmd <= 1'b0;
    wt(6);
    pulse(3'h1);
    chk(applied_set, 2'h2);
    chk(param_value, 16'h5a02);
    bus(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0);
    nrst <= 1'b0;
    wt(2);
    chk(applied_set, 2'h0);
    nrst <= 1'b1;
    wt(6);
    chk(applied_set, 2'h0);
    summarize();
  end
endmodule
